// ---- shared/dlcr_defs.vh ----
// Constants for the line control register bank: offsets, fields, resets and timing.
//
// Overview of operation
// RULE_01 - Hook/ring bit 6 reads the live negative ring level; read-only.
// RULE_02 - Hook/ring bit 5 reads the live positive ring level; read-only.
// RULE_03 - Hook/ring bit 3 enables low-power on-hook line monitoring for caller ID.
// RULE_04 - With full-wave setting 0 only a positive ring sets ring indication bit 2.
// RULE_05 - With full-wave setting 1 a ring of either polarity sets ring indication.
// RULE_06 - Ring indication clears 5 seconds after the last positive ring; in full-wave mode the code also restarts the hold on a negative ring.
// RULE_07 - Ring indication clears at once when off-hook is commanded; the code keeps it set if a ring is present in that cycle.
// RULE_08 - Hook/ring bit 0 set drives the line off-hook; clear returns on-hook.
// RULE_09 - Power bit 4 holds the line side in low power; resets to 1.
// RULE_10 - Host programs the clock generator before clearing line-side power-down.
// RULE_11 - Power bit 3 set powers down the system side.
// RULE_12 - System-side power-down holds until a reset pulse is applied.
// RULE_13 - Sample rate bit 3 selects 8 kHz (0) or 16 kHz (1) sampling.
// RULE_14 - At 16 kHz the frame stays 8 kHz with two samples in adjacent slots.
// RULE_15 - Loopback bit 0 sends serial receive data unchanged to serial transmit.
// RULE_16 - Reserved bits and registers eight and nine read zero, ignore writes.
`ifndef DLCR_DEFS_VH
`define DLCR_DEFS_VH

`define DLCR_IDX_HOOK_RING      5'h05
`define DLCR_IDX_POWER          5'h06
`define DLCR_IDX_SAMPLE_RATE    5'h07
`define DLCR_IDX_RESERVED_EIGHT 5'h08
`define DLCR_IDX_RESERVED_NINE  5'h09
`define DLCR_IDX_LOOPBACK       5'h0A
`define DLCR_IDX_IRQ_STATUS     5'h10
`define DLCR_IDX_IRQ_ENABLE     5'h11
`define DLCR_IDX_IRQ_CLEAR      5'h12
`define DLCR_IDX_RING_CONFIG    5'h13

`define DLCR_BIT_RING_NEG       6
`define DLCR_BIT_RING_POS       5
`define DLCR_BIT_ONHOOK_MON     3
`define DLCR_BIT_RING_IND       2
`define DLCR_BIT_OFF_HOOK       0
`define DLCR_BIT_LINE_PD        4
`define DLCR_BIT_SYSTEM_PD      3
`define DLCR_BIT_DOUBLE_RATE    3
`define DLCR_BIT_LOOPBACK       0
`define DLCR_BIT_FULL_WAVE      0

`define DLCR_IRQ_POS_RING       0
`define DLCR_IRQ_NEG_RING       1
`define DLCR_IRQ_RING_TIMEOUT   2
`define DLCR_IRQ_WIDTH          3

`define DLCR_RST_POWER          8'h10
`define DLCR_RST_ZERO           8'h00

`define DLCR_CLK_KHZ            25000
`define DLCR_RING_HOLD_MS       5000
`define DLCR_RING_HOLD_CYCLES   (`DLCR_RING_HOLD_MS * `DLCR_CLK_KHZ)
`define DLCR_SLOT_CYCLES        8

`endif

// ---- design/dlcr_regs.v ----
// Line control register bank with APB slave, ring timing, sampling slots and loopback.
`timescale 1ns/1ps
`include "dlcr_defs.vh"

module dlcr_regs #(
   parameter [26:0] RING_HOLD_CYCLES = `DLCR_RING_HOLD_CYCLES,
   parameter [7:0]  SLOT_CYCLES      = `DLCR_SLOT_CYCLES
) (
   input  wire        REF_CLK,              // 25 MHz clock
   input  wire        RST_N,                // asynchronous reset, active low
   input  wire        CE_IN,                // clock enable, freezes all state when low
   input  wire        PSEL,                 // APB select
   input  wire        PENABLE,              // APB access phase
   input  wire        PWRITE,               // APB direction, high for write
   input  wire [7:0]  PADDR,                // APB byte address
   input  wire [31:0] PWDATA,               // APB write data
   output reg  [31:0] PRDATA,               // APB read data
   output reg         PREADY,               // APB ready
   output reg         PSLVERR,              // APB error for unmapped address
   input  wire        RING_POS_IN,          // positive ring detector pin
   input  wire        RING_NEG_IN,          // negative ring detector pin
   input  wire        FRAME_SYNC_IN,        // 8 kHz highway frame sync pin
   input  wire        SERIAL_RX_DATA_IN,    // serial receive data pin
   input  wire        TX_PATH_DATA_IN,      // filtered transmit data, same clock
   output reg         SERIAL_TX_DATA_OUT,   // serial transmit data
   output reg         OFF_HOOK_OUT,         // line-side off-hook command
   output reg         ONHOOK_MONITOR_OUT,   // low-power on-hook monitor enable
   output reg         LINE_POWERDOWN_OUT,   // line-side low-power state
   output reg         SYSTEM_POWERDOWN_OUT, // system-side powered down
   output reg         DOUBLE_RATE_OUT,      // 16 kHz sampling selected
   output reg         SAMPLE_SLOT_PULSE,    // one pulse per sample timeslot
   output reg         IRQ_OUT               // level interrupt, active high
);

   reg [2:0] ring_pos_sync_reg;
   reg [2:0] ring_neg_sync_reg;
   reg [2:0] frame_sync_reg;
   reg [2:0] rx_sync_reg;
   reg       ring_pos_lvl_reg;
   reg       ring_neg_lvl_reg;
   reg       frame_lvl_reg;
   reg       rx_lvl_reg;

   reg        off_hook_reg;
   reg        onhook_line_monitor_reg;
   reg        ring_indication_reg;
   reg        line_side_powerdown_reg;
   reg        system_side_powerdown_reg;
   reg        double_rate_sampling_reg;
   reg        digital_loopback_reg;
   reg        full_wave_ring_setting_reg;
   reg [`DLCR_IRQ_WIDTH-1:0] irq_status_reg;
   reg [`DLCR_IRQ_WIDTH-1:0] irq_enable_reg;
   reg [26:0] ring_timer_reg;
   reg [7:0]  slot_timer_reg;
   reg        second_slot_reg;

   wire [4:0] idx      = PADDR[6:2];
   wire       mapped   = map_hit(PADDR);
   wire       access   = PSEL & PENABLE & PREADY;
   wire       wr_en    = access & PWRITE & mapped & ~system_side_powerdown_reg;
   wire       wr_hook  = wr_en & (idx == `DLCR_IDX_HOOK_RING);
   wire       wr_power = wr_en & (idx == `DLCR_IDX_POWER);
   wire       wr_rate  = wr_en & (idx == `DLCR_IDX_SAMPLE_RATE);
   wire       wr_loop  = wr_en & (idx == `DLCR_IDX_LOOPBACK);
   wire       wr_ien   = wr_en & (idx == `DLCR_IDX_IRQ_ENABLE);
   wire       wr_iclr  = wr_en & (idx == `DLCR_IDX_IRQ_CLEAR);
   wire       wr_cfg   = wr_en & (idx == `DLCR_IDX_RING_CONFIG);

   wire       pos_ring  = ring_pos_sync_reg[1] == ring_pos_sync_reg[2] ?
                          ring_pos_sync_reg[1] : ring_pos_lvl_reg;
   wire       neg_ring  = ring_neg_sync_reg[1] == ring_neg_sync_reg[2] ?
                          ring_neg_sync_reg[1] : ring_neg_lvl_reg;
   wire       frame_now = frame_sync_reg[1] == frame_sync_reg[2] ?
                          frame_sync_reg[1] : frame_lvl_reg;
   wire       rx_now    = rx_sync_reg[1] == rx_sync_reg[2] ?
                          rx_sync_reg[1] : rx_lvl_reg;
   wire       pos_rise  = pos_ring & ~ring_pos_lvl_reg;
   wire       neg_rise  = neg_ring & ~ring_neg_lvl_reg;
   wire       frame_rise = frame_now & ~frame_lvl_reg;

   wire       off_hook_next = wr_hook ? PWDATA[`DLCR_BIT_OFF_HOOK] : off_hook_reg;
   // A negative ring only counts in full-wave mode.
   wire       ring_set = pos_ring |
                         (full_wave_ring_setting_reg & neg_ring); // see RULE_04, RULE_05
   wire       ring_timeout = ring_indication_reg & ~ring_set & (ring_timer_reg == 27'h0);
   wire       off_hook_cmd = off_hook_next & ~off_hook_reg;
   wire [`DLCR_IRQ_WIDTH-1:0] irq_events = {ring_timeout, neg_rise, pos_rise};
   wire [`DLCR_IRQ_WIDTH-1:0] irq_clear  = wr_iclr ? PWDATA[`DLCR_IRQ_WIDTH-1:0] :
                                           {`DLCR_IRQ_WIDTH{1'b0}};

   // Word-aligned addresses of mapped registers only; reserved eight and nine are mapped.
   function map_hit;
      input [7:0] addr;
      begin
         map_hit = (addr[1:0] == 2'b00) && (addr[7] == 1'b0) &&
                   ((addr[6:2] >= `DLCR_IDX_HOOK_RING && addr[6:2] <= `DLCR_IDX_LOOPBACK) ||
                    (addr[6:2] >= `DLCR_IDX_IRQ_STATUS && addr[6:2] <= `DLCR_IDX_RING_CONFIG));
      end
   endfunction

   function [7:0] read_word;
      input [4:0] ridx;
      begin
         read_word = 8'h00; // see RULE_16
         case (ridx)
            `DLCR_IDX_HOOK_RING: begin
               read_word[`DLCR_BIT_RING_NEG]   = ring_neg_lvl_reg;        // see RULE_01
               read_word[`DLCR_BIT_RING_POS]   = ring_pos_lvl_reg;        // see RULE_02
               read_word[`DLCR_BIT_ONHOOK_MON] = onhook_line_monitor_reg;
               read_word[`DLCR_BIT_RING_IND]   = ring_indication_reg;
               read_word[`DLCR_BIT_OFF_HOOK]   = off_hook_reg;
            end
            `DLCR_IDX_POWER: begin
               read_word[`DLCR_BIT_LINE_PD]   = line_side_powerdown_reg;
               read_word[`DLCR_BIT_SYSTEM_PD] = system_side_powerdown_reg;
            end
            `DLCR_IDX_SAMPLE_RATE: begin
               read_word[`DLCR_BIT_DOUBLE_RATE] = double_rate_sampling_reg;
            end
            `DLCR_IDX_LOOPBACK: begin
               read_word[`DLCR_BIT_LOOPBACK] = digital_loopback_reg;
            end
            `DLCR_IDX_IRQ_STATUS: begin
               read_word[`DLCR_IRQ_WIDTH-1:0] = irq_status_reg;
            end
            `DLCR_IDX_IRQ_ENABLE: begin
               read_word[`DLCR_IRQ_WIDTH-1:0] = irq_enable_reg;
            end
            `DLCR_IDX_RING_CONFIG: begin
               read_word[`DLCR_BIT_FULL_WAVE] = full_wave_ring_setting_reg;
            end
            default: begin
               read_word = 8'h00;
            end
         endcase
      end
   endfunction

   // Pin synchronisers; a level is accepted once the second and third stages agree.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ring_pos_sync_reg <= 3'h0;
         ring_neg_sync_reg <= 3'h0;
         frame_sync_reg    <= 3'h0;
         rx_sync_reg       <= 3'h0;
         ring_pos_lvl_reg  <= 1'b0;
         ring_neg_lvl_reg  <= 1'b0;
         frame_lvl_reg     <= 1'b0;
         rx_lvl_reg        <= 1'b0;
      end else if (CE_IN) begin
         ring_pos_sync_reg <= {ring_pos_sync_reg[1:0], RING_POS_IN};
         ring_neg_sync_reg <= {ring_neg_sync_reg[1:0], RING_NEG_IN};
         frame_sync_reg    <= {frame_sync_reg[1:0], FRAME_SYNC_IN};
         rx_sync_reg       <= {rx_sync_reg[1:0], SERIAL_RX_DATA_IN};
         ring_pos_lvl_reg  <= pos_ring;
         ring_neg_lvl_reg  <= neg_ring;
         frame_lvl_reg     <= frame_now;
         rx_lvl_reg        <= rx_now;
      end
   end

   // APB slave answers with PREADY one cycle into the access phase.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else if (CE_IN) begin
         PREADY  <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
         if (PSEL & PENABLE & ~PREADY & ~PWRITE & mapped) begin
            PRDATA <= {24'h0, read_word(idx)};
         end else begin
            PRDATA <= 32'h0;
         end
      end
   end

   // Control registers; a system-side power-down blocks all writes until reset.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         off_hook_reg               <= 1'b0;
         onhook_line_monitor_reg    <= 1'b0;
         line_side_powerdown_reg    <= 1'b1; // see RULE_09
         system_side_powerdown_reg  <= 1'b0;
         double_rate_sampling_reg   <= 1'b0;
         digital_loopback_reg       <= 1'b0;
         full_wave_ring_setting_reg <= 1'b0;
         irq_enable_reg             <= {`DLCR_IRQ_WIDTH{1'b0}};
      end else if (CE_IN) begin
         off_hook_reg <= off_hook_next; // see RULE_08
         if (wr_hook) begin
            onhook_line_monitor_reg <= PWDATA[`DLCR_BIT_ONHOOK_MON]; // see RULE_03
         end
         if (wr_power) begin
            line_side_powerdown_reg   <= PWDATA[`DLCR_BIT_LINE_PD];   // see RULE_09
            system_side_powerdown_reg <= PWDATA[`DLCR_BIT_SYSTEM_PD]; // see RULE_11, RULE_12
         end
         if (wr_rate) begin
            double_rate_sampling_reg <= PWDATA[`DLCR_BIT_DOUBLE_RATE]; // see RULE_13
         end
         if (wr_loop) begin
            digital_loopback_reg <= PWDATA[`DLCR_BIT_LOOPBACK];
         end
         if (wr_ien) begin
            irq_enable_reg <= PWDATA[`DLCR_IRQ_WIDTH-1:0];
         end
         if (wr_cfg) begin
            full_wave_ring_setting_reg <= PWDATA[`DLCR_BIT_FULL_WAVE];
         end
      end
   end

   // Ring indication with hold timer; a new ring wins over the off-hook clear.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ring_indication_reg <= 1'b0;
         ring_timer_reg      <= 27'h0;
      end else if (CE_IN) begin
         if (ring_set) begin
            ring_indication_reg <= 1'b1;                   // see RULE_04, RULE_05
            ring_timer_reg      <= RING_HOLD_CYCLES - 27'h1; // see RULE_06
         end else if (off_hook_cmd) begin
            ring_indication_reg <= 1'b0;                   // see RULE_07
            ring_timer_reg      <= 27'h0;
         end else if (ring_timeout) begin
            ring_indication_reg <= 1'b0;                   // see RULE_06
         end else if (ring_timer_reg != 27'h0) begin
            ring_timer_reg <= ring_timer_reg - 27'h1;
         end
      end
   end

   // Sticky interrupt status; an event in the clearing cycle keeps its bit set.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_status_reg <= {`DLCR_IRQ_WIDTH{1'b0}};
         IRQ_OUT        <= 1'b0;
      end else if (CE_IN) begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
         IRQ_OUT        <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // Sample slots: one per frame, or two in adjacent slots at double rate.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         slot_timer_reg    <= 8'h00;
         second_slot_reg   <= 1'b0;
         SAMPLE_SLOT_PULSE <= 1'b0;
      end else if (CE_IN) begin
         SAMPLE_SLOT_PULSE <= 1'b0;
         if (frame_rise) begin
            SAMPLE_SLOT_PULSE <= 1'b1;
            second_slot_reg   <= double_rate_sampling_reg; // see RULE_14
            slot_timer_reg    <= SLOT_CYCLES - 8'h01;
         end else if (second_slot_reg) begin
            if (slot_timer_reg == 8'h00) begin
               SAMPLE_SLOT_PULSE <= 1'b1;                  // see RULE_14
               second_slot_reg   <= 1'b0;
            end else begin
               slot_timer_reg <= slot_timer_reg - 8'h01;
            end
         end
      end
   end

   // Output flops for control levels and the serial transmit path.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SERIAL_TX_DATA_OUT   <= 1'b0;
         OFF_HOOK_OUT         <= 1'b0;
         ONHOOK_MONITOR_OUT   <= 1'b0;
         LINE_POWERDOWN_OUT   <= 1'b1;
         SYSTEM_POWERDOWN_OUT <= 1'b0;
         DOUBLE_RATE_OUT      <= 1'b0;
      end else if (CE_IN) begin
         SERIAL_TX_DATA_OUT   <= digital_loopback_reg ? rx_lvl_reg :
                                 TX_PATH_DATA_IN; // see RULE_15
         OFF_HOOK_OUT         <= off_hook_reg;
         ONHOOK_MONITOR_OUT   <= onhook_line_monitor_reg;  // see RULE_03
         LINE_POWERDOWN_OUT   <= line_side_powerdown_reg;
         SYSTEM_POWERDOWN_OUT <= system_side_powerdown_reg; // see RULE_12
         DOUBLE_RATE_OUT      <= double_rate_sampling_reg;
      end
   end

endmodule

// ---- bench/dlcr_regs_assertions.sv ----
// Port-level assertions for the line control register bank.
`timescale 1ns/1ps
module dlcr_regs_assertions #(
   parameter int SLOT_CYCLES = 4
) (
   input logic        REF_CLK,              // clock
   input logic        RST_N,                // reset, active low
   input logic        PSEL,                 // APB select
   input logic        PENABLE,              // APB access phase
   input logic        PWRITE,               // APB direction
   input logic [7:0]  PADDR,                // APB address
   input logic [31:0] PWDATA,               // APB write data
   input logic [31:0] PRDATA,               // APB read data
   input logic        PREADY,               // APB ready
   input logic        PSLVERR,              // APB error
   input logic        RING_POS_IN,          // positive ring pin
   input logic        RING_NEG_IN,          // negative ring pin
   input logic        OFF_HOOK_OUT,         // off-hook command
   input logic        ONHOOK_MONITOR_OUT,   // monitor enable
   input logic        LINE_POWERDOWN_OUT,   // line side low power
   input logic        SYSTEM_POWERDOWN_OUT, // system side down
   input logic        DOUBLE_RATE_OUT,      // 16 kHz sampling
   input logic        SAMPLE_SLOT_PULSE     // slot pulse
);
   logic [1:0] pin_last_reg;
   logic [2:0] stab_reg;
   logic [7:0] wbyte_reg;
   logic       wr_ok;
   logic       rd_hook;
   assign wr_ok = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR && !SYSTEM_POWERDOWN_OUT;
   assign rd_hook = PSEL && PREADY && !PWRITE && PADDR == 8'h14;
   // Counts how long both ring pins have been steady, so the synchroniser has settled.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_last_reg <= 2'h0;
         stab_reg <= 3'h0;
         wbyte_reg <= 8'h00;
      end else begin
         pin_last_reg <= {RING_NEG_IN, RING_POS_IN};
         stab_reg <= (pin_last_reg != {RING_NEG_IN, RING_POS_IN}) ? 3'h0 :
                     (stab_reg == 3'h7) ? 3'h7 : stab_reg + 3'h1;
         wbyte_reg <= wr_ok ? PWDATA[7:0] : wbyte_reg;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   property p_ctl(logic [7:0] a, logic b, logic o);
      wr_ok && PADDR == a |-> ##2 o == b;
   endproperty
   AST_RING_NEG_FLAG: assert property (
      rd_hook && stab_reg == 3'h7 |-> PRDATA[6] == RING_NEG_IN)
      else $error("negative ring flag differs from pin");
   AST_RING_POS_FLAG: assert property (
      rd_hook && stab_reg == 3'h7 |-> PRDATA[5] == RING_POS_IN)
      else $error("positive ring flag differs from pin");
   AST_MONITOR: assert property (p_ctl(8'h14, wbyte_reg[3], ONHOOK_MONITOR_OUT))
      else $error("monitor output does not follow write");
   AST_OFF_HOOK: assert property (p_ctl(8'h14, wbyte_reg[0], OFF_HOOK_OUT))
      else $error("off-hook output does not follow write");
   AST_SYS_PD_SET: assert property (
      p_ctl(8'h18, wbyte_reg[3], SYSTEM_POWERDOWN_OUT))
      else $error("system powerdown does not follow write");
   AST_RATE: assert property (p_ctl(8'h1C, wbyte_reg[3], DOUBLE_RATE_OUT))
      else $error("double rate output does not follow write");
   AST_RESET_STATE: assert property (
      !$past(RST_N) |-> LINE_POWERDOWN_OUT && !OFF_HOOK_OUT)
      else $error("wrong output state after reset");
   AST_SYS_PD_HOLD: assert property (SYSTEM_POWERDOWN_OUT |=> SYSTEM_POWERDOWN_OUT)
      else $error("system powerdown left without reset");
   AST_SLOT_PAIR: assert property (SAMPLE_SLOT_PULSE && DOUBLE_RATE_OUT &&
      !$past(SAMPLE_SLOT_PULSE, SLOT_CYCLES) |-> ##SLOT_CYCLES SAMPLE_SLOT_PULSE)
      else $error("second sample slot missing");
   AST_RESERVED: assert property (PSEL && PREADY && !PWRITE &&
      (PADDR == 8'h20 || PADDR == 8'h24) |-> PRDATA == 32'h0)
      else $error("reserved register reads nonzero");
   COV_DOUBLE: cover property (SAMPLE_SLOT_PULSE && DOUBLE_RATE_OUT);
   COV_ERR: cover property (PREADY && PSLVERR);
   COV_SYS_PD: cover property (SYSTEM_POWERDOWN_OUT);
endmodule
bind dlcr_regs dlcr_regs_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .RING_POS_IN(RING_POS_IN), .RING_NEG_IN(RING_NEG_IN), .OFF_HOOK_OUT(OFF_HOOK_OUT),
   .ONHOOK_MONITOR_OUT(ONHOOK_MONITOR_OUT), .LINE_POWERDOWN_OUT(LINE_POWERDOWN_OUT),
   .SYSTEM_POWERDOWN_OUT(SYSTEM_POWERDOWN_OUT), .DOUBLE_RATE_OUT(DOUBLE_RATE_OUT),
   .SAMPLE_SLOT_PULSE(SAMPLE_SLOT_PULSE));

// ---- bench/dlcr_line_model.sv ----
// Far-side line model: ring detector levels, frame sync and serial data.
`timescale 1ns/1ps
module dlcr_line_model #(
   parameter int FRAME_CYCLES = 40
) (
   input  logic clk,          // system clock
   input  logic ring_pos_cmd, // request a positive ring
   input  logic ring_neg_cmd, // request a negative ring
   input  logic rx_cmd,       // serial receive bit to present
   output logic ring_pos_pin, // positive ring detector level
   output logic ring_neg_pin, // negative ring detector level
   output logic frame_pin,    // highway frame sync
   output logic rx_pin,       // serial receive data
   output logic tx_path       // filtered transmit data, opposite of rx
);
   int cnt = 0;
   assign ring_pos_pin = ring_pos_cmd;
   assign ring_neg_pin = ring_neg_cmd;
   assign rx_pin = rx_cmd;
   assign tx_path = ~rx_cmd;
   // The highway frame runs at one fixed rate whatever the sample rate.
   always @(posedge clk) begin
      cnt <= (cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
   end
   assign frame_pin = (cnt < 2);
endmodule

// ---- bench/test_daa_line_control_regs.sv ----
// Self-checking bench for the line control register bank.
`timescale 1ns/1ps
module test_daa_line_control_regs;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pos_cmd = 1'b0;
   logic        neg_cmd = 1'b0;
   logic        rx_cmd = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, rpos, rneg, frame, rx, txp, tx_out, off_hook, mon;
   logic        line_pd, sys_pd, rate, slot, irq;
   int          mismatches = 0;
   int          checks = 0;
   int          cycles = 0;
   int          n;
   dlcr_line_model line_u (.clk(ref_clk), .ring_pos_cmd(pos_cmd), .ring_neg_cmd(neg_cmd),
      .rx_cmd(rx_cmd), .ring_pos_pin(rpos), .ring_neg_pin(rneg), .frame_pin(frame),
      .rx_pin(rx), .tx_path(txp));
   dlcr_regs #(.RING_HOLD_CYCLES(27'h32), .SLOT_CYCLES(8'h04)) dut_u (.REF_CLK(ref_clk),
      .RST_N(rst_n), .CE_IN(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RING_POS_IN(rpos), .RING_NEG_IN(rneg), .FRAME_SYNC_IN(frame), .SERIAL_RX_DATA_IN(rx),
      .TX_PATH_DATA_IN(txp), .SERIAL_TX_DATA_OUT(tx_out), .OFF_HOOK_OUT(off_hook),
      .ONHOOK_MONITOR_OUT(mon), .LINE_POWERDOWN_OUT(line_pd),
      .SYSTEM_POWERDOWN_OUT(sys_pd), .DOUBLE_RATE_OUT(rate), .SAMPLE_SLOT_PULSE(slot),
      .IRQ_OUT(irq));
   always #20 ref_clk = ~ref_clk;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bchk(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready.
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic t_reset_values;
      rdc(8'h14, 32'h00);
      rdc(8'h18, 32'h10);
      rdc(8'h1C, 32'h00);
      rdc(8'h28, 32'h00);
      wr(8'h20, 32'hFF);
      rdc(8'h20, 32'h00);
      rdc(8'h24, 32'h00);
      apb(1'b0, 8'h3C, 32'h0);
      bchk(err, 1'b1);
      $display("test reset values done");
   endtask
   task automatic t_hook;
      wr(8'h14, 32'hFF);
      rdc(8'h14, 32'h09);
      wt(3);
      bchk(mon, 1'b1);
      bchk(off_hook, 1'b1);
      wr(8'h14, 32'h00);
      wt(3);
      bchk(off_hook, 1'b0);
      wr(8'h18, 32'h00);
      wt(3);
      bchk(line_pd, 1'b0);
      $display("test hook done");
   endtask
   task automatic t_ring;
      wr(8'h48, 32'h07);
      wr(8'h44, 32'h01);
      neg_cmd <= 1'b1;
      wt(10);
      rdc(8'h14, 32'h40);
      bchk(irq, 1'b0);
      neg_cmd <= 1'b0;
      wt(10);
      pos_cmd <= 1'b1;
      wt(10);
      rdc(8'h14, 32'h24);
      bchk(irq, 1'b1);
      wr(8'h48, 32'h07);
      wt(3);
      bchk(irq, 1'b0);
      pos_cmd <= 1'b0;
      wt(20);
      rdc(8'h14, 32'h04);
      wt(60);
      rdc(8'h14, 32'h00);
      wr(8'h4C, 32'h01);
      neg_cmd <= 1'b1;
      wt(10);
      rdc(8'h14, 32'h44);
      neg_cmd <= 1'b0;
      wt(10);
      wr(8'h14, 32'h01);
      rdc(8'h14, 32'h01);
      wr(8'h14, 32'h00);
      wr(8'h44, 32'h00);
      $display("test ring done");
   endtask
   task automatic count_slots(input int exp);
      n = 0;
      repeat (80) begin
         @(posedge ref_clk);
         n += (slot === 1'b1);
      end
      chk(n, exp);
   endtask
   task automatic t_rate_loop;
      count_slots(2);
      wr(8'h1C, 32'h08);
      wt(3);
      bchk(rate, 1'b1);
      count_slots(4);
      wr(8'h28, 32'h01);
      rx_cmd <= 1'b1;
      wt(8);
      bchk(tx_out, 1'b1);
      rx_cmd <= 1'b0;
      wt(8);
      bchk(tx_out, 1'b0);
      wr(8'h28, 32'h00);
      wt(3);
      bchk(tx_out, 1'b1);
      $display("test rate and loopback done");
   endtask
   task automatic t_sys_pd;
      wr(8'h18, 32'h08);
      wt(3);
      bchk(sys_pd, 1'b1);
      wr(8'h14, 32'h01);
      rdc(8'h14, 32'h00);
      rst_n <= 1'b0;
      wt(3);
      rst_n <= 1'b1;
      wt(2);
      bchk(sys_pd, 1'b0);
      rdc(8'h18, 32'h10);
      $display("test system powerdown done");
   endtask
   initial begin
      wt(3);
      rst_n <= 1'b1;
      t_reset_values;
      t_hook;
      t_ring;
      t_rate_loop;
      t_sys_pd;
      wrap_up;
   end
endmodule
